// file: design/x86rf_regfile.v
// general purpose and segment register file of an x86-class core
// assumes the pipeline drives requests on clk_i and reads results a cycle
// later; ce_i low freezes every register except the two reset release flops
//
// Functional notes
// - extended name reads/writes full 32 bits
// - word name selects only low 16 bits
// - high and low bytes written independently
// - pointers/indices addressable as 16 or 32 bits
// - string repeat uses source, dest, count registers
// - stack pointer auto-adjusts on stack operations
// - six 16-bit segment registers provided
// - default segments: data, stack, code
// - fetch, stack, string dest ignore override
// - override prefix redirects other references
// - real/v86 and protected segment interpretation differ
`timescale 1ns/1ps
`default_nettype none
`include "x86rf_consts.vh"

module x86rf_regfile (
    // clock and reset
    input  wire        clk_i,
    input  wire        rstn_i,
    input  wire        ce_i,
    // explicit read port a
    input  wire [2:0]  rd_a_idx_i,
    input  wire [1:0]  rd_a_size_i,
    output reg  [31:0] rd_a_data_o,
    // explicit read port b
    input  wire [2:0]  rd_b_idx_i,
    input  wire [1:0]  rd_b_size_i,
    output reg  [31:0] rd_b_data_o,
    // explicit write port
    input  wire        wr_en_i,
    input  wire [2:0]  wr_idx_i,
    input  wire [1:0]  wr_size_i,
    input  wire [31:0] wr_data_i,
    // string repeat step
    input  wire        str_step_i,
    input  wire        str_dir_dec_i,
    input  wire        str_src_en_i,
    input  wire        str_dst_en_i,
    input  wire        str_rep_i,
    input  wire [2:0]  str_elem_bytes_i,
    input  wire        str_addr32_i,
    output reg  [31:0] str_src_o,
    output reg  [31:0] str_dst_o,
    output reg  [31:0] str_count_o,
    output wire        str_count_zero_o,
    // stack adjust
    input  wire [1:0]  stk_op_i,
    input  wire [2:0]  stk_bytes_i,
    input  wire        stk_addr32_i,
    output reg  [31:0] stack_ptr_o,
    // segment write
    input  wire        seg_wr_en_i,
    input  wire [2:0]  seg_wr_idx_i,
    input  wire [15:0] seg_wr_data_i,
    // segment selection
    input  wire [2:0]  ref_kind_i,
    input  wire        ovr_valid_i,
    input  wire [2:0]  ovr_seg_i,
    input  wire        prot_mode_i,
    input  wire        v86_mode_i,
    output reg  [2:0]  seg_sel_idx_o,
    output wire [15:0] seg_value_o,
    output reg  [31:0] seg_real_base_o,
    output reg  [15:0] seg_selector_o,
    output reg         seg_is_selector_o
);
    reg        rst_s1_r;
    reg        rst_n_r;
    reg [31:0] gpr_r [0:7];
    reg [31:0] gpr_nxt [0:7];
    reg [2:0]  seg_sel_nxt;
    reg [31:0] rd_a_nxt;
    reg [31:0] rd_b_nxt;
    reg [31:0] str_step_amt;
    reg [31:0] stk_amt;
    reg [31:0] tmp;
    reg        mode_prot_r;
    integer    i;

    // reset released through two flip-flops
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    // sized read of a general register
    function [31:0] rd_sized;
        input [31:0] v;
        input [1:0]  sz;
        begin
            case (sz)
                `X86RF_SZ_W32:  rd_sized = v;
                `X86RF_SZ_W16:  rd_sized = {16'h0000, v[15:0]};
                `X86RF_SZ_HIGH8: rd_sized = {24'h000000, v[15:8]};
                default:        rd_sized = {24'h000000, v[7:0]};
            endcase
        end
    endfunction

    // merge a sized write into a general register
    function [31:0] wr_sized;
        input [31:0] old;
        input [31:0] d;
        input [1:0]  sz;
        begin
            case (sz)
                `X86RF_SZ_W32:  wr_sized = d;
                `X86RF_SZ_W16:  wr_sized = {old[31:16], d[15:0]};
                `X86RF_SZ_HIGH8: wr_sized = {old[31:16], d[7:0], old[7:0]};
                default:        wr_sized = {old[31:8], d[7:0]};
            endcase
        end
    endfunction

    // add or subtract at 16 or 32 bit address width
    function [31:0] ptr_adj;
        input [31:0] v;
        input [31:0] amt;
        input        dec;
        input        a32;
        begin
            ptr_adj = dec ? v - amt : v + amt;
            if (!a32)
                ptr_adj = {v[31:16], ptr_adj[15:0]};
        end
    endfunction

    // byte lanes only exist on the four data registers; pointers and
    // indices treat a byte request as a word access
    function [1:0] eff_size;
        input [2:0] idx;
        input [1:0] sz;
        begin
            if (idx > `X86RF_BASE && !sz[1])
                eff_size = `X86RF_SZ_W16;
            else
                eff_size = sz;
        end
    endfunction

    // general register next state
    always @* begin
        str_step_amt = {29'h0, str_elem_bytes_i};
        stk_amt      = {29'h0, stk_bytes_i};
        tmp          = 32'h0;
        for (i = 0; i < 8; i = i + 1)
            gpr_nxt[i] = gpr_r[i];
        if (wr_en_i)
            gpr_nxt[wr_idx_i] = wr_sized(gpr_r[wr_idx_i], wr_data_i,
                                         eff_size(wr_idx_i, wr_size_i));
        // implicit operands win over an explicit write in the same cycle
        if (str_step_i) begin
            if (str_src_en_i)
                gpr_nxt[`X86RF_SRC_IDX] = ptr_adj(gpr_r[`X86RF_SRC_IDX],
                    str_step_amt, str_dir_dec_i, str_addr32_i);
            if (str_dst_en_i)
                gpr_nxt[`X86RF_DST_IDX] = ptr_adj(gpr_r[`X86RF_DST_IDX],
                    str_step_amt, str_dir_dec_i, str_addr32_i);
            if (str_rep_i && !str_count_zero_o) begin
                tmp = ptr_adj(gpr_r[`X86RF_COUNT], 32'h1, 1'b1,
                              str_addr32_i);
                gpr_nxt[`X86RF_COUNT] = tmp;
            end
        end
        case (stk_op_i)
            `X86RF_STK_PUSH: gpr_nxt[`X86RF_STACK_PTR] =
                ptr_adj(gpr_r[`X86RF_STACK_PTR], stk_amt, 1'b1,
                        stk_addr32_i);
            `X86RF_STK_POP: gpr_nxt[`X86RF_STACK_PTR] =
                ptr_adj(gpr_r[`X86RF_STACK_PTR], stk_amt, 1'b0,
                        stk_addr32_i);
            default: ;
        endcase
    end

    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_gpr
            always @(posedge clk_i or negedge rst_n_r) begin
                if (!rst_n_r)
                    gpr_r[g] <= `X86RF_GPR_RST;
                else if (ce_i)
                    gpr_r[g] <= gpr_nxt[g];
            end
        end
    endgenerate

    // read data and implicit register views
    always @* begin
        rd_a_nxt = rd_sized(gpr_r[rd_a_idx_i],
                            eff_size(rd_a_idx_i, rd_a_size_i));
        rd_b_nxt = rd_sized(gpr_r[rd_b_idx_i],
                            eff_size(rd_b_idx_i, rd_b_size_i));
    end

    assign str_count_zero_o = str_addr32_i ?
        (gpr_r[`X86RF_COUNT] == 32'h0) :
        (gpr_r[`X86RF_COUNT][15:0] == 16'h0);

    always @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rd_a_data_o <= 32'h0;
            rd_b_data_o <= 32'h0;
            str_src_o   <= 32'h0;
            str_dst_o   <= 32'h0;
            str_count_o <= 32'h0;
            stack_ptr_o <= 32'h0;
        end else if (ce_i) begin
            rd_a_data_o <= rd_a_nxt;
            rd_b_data_o <= rd_b_nxt;
            str_src_o   <= gpr_nxt[`X86RF_SRC_IDX];
            str_dst_o   <= gpr_nxt[`X86RF_DST_IDX];
            str_count_o <= gpr_nxt[`X86RF_COUNT];
            stack_ptr_o <= gpr_nxt[`X86RF_STACK_PTR];
        end
    end

    // segment selection for the reference kind
    always @* begin
        case (ref_kind_i)
            `X86RF_REF_FETCH:  seg_sel_nxt = `X86RF_SEG_CODE;
            `X86RF_REF_STACK:  seg_sel_nxt = `X86RF_SEG_STACK;
            `X86RF_REF_STRDST: seg_sel_nxt = `X86RF_SEG_EXTRA;
            `X86RF_REF_BPDATA: seg_sel_nxt = `X86RF_SEG_STACK;
            default:           seg_sel_nxt = `X86RF_SEG_DATA;
        endcase
        if (ovr_valid_i && ovr_seg_i < 3'h6 &&
            (ref_kind_i == `X86RF_REF_DATA ||
             ref_kind_i == `X86RF_REF_STRSRC ||
             ref_kind_i == `X86RF_REF_BPDATA))
            seg_sel_nxt = ovr_seg_i;
    end

    always @(posedge clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            seg_sel_idx_o <= `X86RF_SEG_DATA;
            mode_prot_r   <= 1'b0;
        end else if (ce_i) begin
            seg_sel_idx_o <= seg_sel_nxt;
            // virtual 8086 follows the real mode interpretation
            mode_prot_r   <= prot_mode_i && !v86_mode_i;
        end
    end

    x86rf_seg_bank u_seg (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_r),
        .ce_i      (ce_i),
        .we_i      (seg_wr_en_i),
        .waddr_i   (seg_wr_idx_i),
        .wdata_i   (seg_wr_data_i),
        .raddr_a_i (seg_sel_nxt),
        .rdata_a_o (seg_value_o),
        .raddr_b_i (seg_wr_idx_i),
        .rdata_b_o ()
    );

    // real mode yields a base; protected mode yields a table selector.
    // descriptor lookup lives outside, so only the selector leaves here
    always @* begin
        seg_is_selector_o = mode_prot_r;
        if (mode_prot_r) begin
            seg_real_base_o = 32'h0;
            seg_selector_o  = seg_value_o;
        end else begin
            seg_real_base_o = {12'h000, seg_value_o, 4'h0};
            seg_selector_o  = 16'h0000;
        end
    end
endmodule // x86rf_regfile

`default_nettype wire

// file: shared/x86rf_consts.vh
// constants for the general and segment register file
// assumes inclusion by bare name from design files
`ifndef X86RF_CONSTS_VH
`define X86RF_CONSTS_VH

// general register indices
`define X86RF_ACC        3'h0
`define X86RF_COUNT      3'h1
`define X86RF_DATA       3'h2
`define X86RF_BASE       3'h3
`define X86RF_STACK_PTR  3'h4
`define X86RF_FRAME_PTR  3'h5
`define X86RF_SRC_IDX    3'h6
`define X86RF_DST_IDX    3'h7

// access sizes
`define X86RF_SZ_LOW8    2'h0
`define X86RF_SZ_HIGH8   2'h1
`define X86RF_SZ_W16     2'h2
`define X86RF_SZ_W32     2'h3

// segment indices
`define X86RF_SEG_EXTRA  3'h0
`define X86RF_SEG_CODE   3'h1
`define X86RF_SEG_STACK  3'h2
`define X86RF_SEG_DATA   3'h3
`define X86RF_SEG_AUX1   3'h4
`define X86RF_SEG_AUX2   3'h5

// reference kinds for segment selection
`define X86RF_REF_FETCH  3'h0
`define X86RF_REF_DATA   3'h1
`define X86RF_REF_STACK  3'h2
`define X86RF_REF_STRDST 3'h3
`define X86RF_REF_STRSRC 3'h4
`define X86RF_REF_BPDATA 3'h5

// stack adjust operations
`define X86RF_STK_NONE   2'h0
`define X86RF_STK_PUSH   2'h1
`define X86RF_STK_POP    2'h2

// reset contents, left clear
`define X86RF_GPR_RST    32'h0000_0000
`define X86RF_SEG_RST    16'h0000

// real mode base shift
`define X86RF_REAL_SHIFT 4

`endif

// file: design/x86rf_seg_bank.v
// six 16-bit segment registers with one write port and two read ports
// assumes its reset input is the parent's synchronised reset copy
`timescale 1ns/1ps
`default_nettype none
`include "x86rf_consts.vh"

module x86rf_seg_bank (
    // clock and reset
    input  wire        clk_i,
    input  wire        rst_n_i,
    input  wire        ce_i,
    // write port
    input  wire        we_i,
    input  wire [2:0]  waddr_i,
    input  wire [15:0] wdata_i,
    // read ports
    input  wire [2:0]  raddr_a_i,
    output reg  [15:0] rdata_a_o,
    input  wire [2:0]  raddr_b_i,
    output reg  [15:0] rdata_b_o
);
    reg [15:0] seg_r [0:5];
    genvar g;

    generate
        for (g = 0; g < 6; g = g + 1) begin : g_seg
            always @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i)
                    seg_r[g] <= `X86RF_SEG_RST;
                else if (ce_i && we_i && waddr_i == g)
                    seg_r[g] <= wdata_i;
            end
        end
    endgenerate

    // registered read data; out of range index reads zero
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_a_o <= 16'h0000;
            rdata_b_o <= 16'h0000;
        end else if (ce_i) begin
            rdata_a_o <= (raddr_a_i < 3'h6) ? seg_r[raddr_a_i] : 16'h0000;
            rdata_b_o <= (raddr_b_i < 3'h6) ? seg_r[raddr_b_i] : 16'h0000;
        end
    end
endmodule // x86rf_seg_bank

`default_nettype wire

// file: sim/x86rf_regfile_chk.sv
// port checker for the register file, one clock domain
// assumes bind onto x86rf_regfile and its two-flop reset release
`timescale 1ns/1ps
`default_nettype none
`include "x86rf_consts.vh"

module x86rf_regfile_chk (
    // clock and reset
    input wire logic        clk_i,
    input wire logic        rstn_i,
    // requests
    input wire logic        ce_i,
    input wire logic        wr_en_i,
    input wire logic [2:0]  wr_idx_i,
    input wire logic [1:0]  wr_size_i,
    input wire logic [31:0] wr_data_i,
    input wire logic        str_addr32_i,
    input wire logic [1:0]  stk_op_i,
    input wire logic [2:0]  stk_bytes_i,
    input wire logic        stk_addr32_i,
    input wire logic [2:0]  ref_kind_i,
    input wire logic        ovr_valid_i,
    input wire logic [2:0]  ovr_seg_i,
    // results
    input wire logic [31:0] str_count_o,
    input wire logic        str_count_zero_o,
    input wire logic [31:0] stack_ptr_o,
    input wire logic [2:0]  seg_sel_idx_o,
    input wire logic [15:0] seg_value_o,
    input wire logic [31:0] seg_real_base_o,
    input wire logic        seg_is_selector_o
);
    // inner reset trails rstn_i by two edges, so wait three
    logic [1:0] up_r;
    logic       go;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i)
            up_r <= 2'h0;
        else if (up_r != 2'h3)
            up_r <= up_r + 2'h1;
    end
    assign go = (up_r == 2'h3) && ce_i;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    a_count_zero_flag: assert property (
        str_count_zero_o == (str_addr32_i ? str_count_o == 32'h0
                                          : str_count_o[15:0] == 16'h0))
        else $error("count zero flag wrong");
    a_fetch_code_seg: assert property (
        go && ref_kind_i == `X86RF_REF_FETCH
        |=> seg_sel_idx_o == `X86RF_SEG_CODE) else $error("fetch seg");
    a_strdst_extra_seg: assert property (
        go && ref_kind_i == `X86RF_REF_STRDST
        |=> seg_sel_idx_o == `X86RF_SEG_EXTRA) else $error("dest seg");
    a_data_default_seg: assert property (
        go && ref_kind_i == `X86RF_REF_DATA && !ovr_valid_i
        |=> seg_sel_idx_o == `X86RF_SEG_DATA) else $error("data seg");
    a_override_taken: assert property (
        go && ref_kind_i == `X86RF_REF_DATA && ovr_valid_i && ovr_seg_i < 3'h6
        |=> seg_sel_idx_o == $past(ovr_seg_i)) else $error("override");
    a_mode_base_form: assert property (
        seg_real_base_o == (seg_is_selector_o ? 32'h0
                            : {12'h0, seg_value_o, 4'h0}))
        else $error("segment base form");
    a_push_moves_sp: assert property (
        go && stk_op_i == `X86RF_STK_PUSH && stk_addr32_i
        |=> stack_ptr_o == $past(stack_ptr_o) - {29'h0, $past(stk_bytes_i)})
        else $error("push adjust");
    a_word_keeps_top: assert property (
        go && wr_en_i && wr_idx_i == `X86RF_STACK_PTR
        && wr_size_i == `X86RF_SZ_W16 && stk_op_i == `X86RF_STK_NONE
        |=> ((stack_ptr_o ^ $past(stack_ptr_o)) >> 16) == 32'h0
        && ((stack_ptr_o ^ $past(wr_data_i)) & 32'hffff) == 32'h0)
        else $error("word write");

    c_push: cover property (go && stk_op_i == `X86RF_STK_PUSH);
    c_override: cover property (go && ovr_valid_i);
    c_word: cover property (go && wr_en_i && wr_size_i == `X86RF_SZ_W16);
endmodule // x86rf_regfile_chk

bind x86rf_regfile x86rf_regfile_chk u_chk (.*);
`default_nettype wire

// file: sim/x86rf_pipe_model.sv
// pipeline-side model: explicit write port and read port a
// assumes its tasks are called at a falling clock edge
`timescale 1ns/1ps
`default_nettype none

module x86rf_pipe_model (
    // clock
    input  wire logic        clk_i,
    // write and read requests
    output var  logic        wr_en_o,
    output var  logic [2:0]  wr_idx_o,
    output var  logic [1:0]  wr_size_o,
    output var  logic [31:0] wr_data_o,
    output var  logic [2:0]  rd_idx_o,
    output var  logic [1:0]  rd_size_o
);
    initial begin
        {wr_en_o, wr_idx_o, wr_size_o, rd_idx_o, rd_size_o} = '0;
        wr_data_o = 32'h0;
    end
    // one write over one rising edge, then one idle edge so that back to
    // back calls never move the strobe twice in one step
    task automatic wr(input logic [2:0] i, input logic [1:0] s,
                      input logic [31:0] d);
        {wr_en_o, wr_idx_o, wr_size_o, wr_data_o} = {1'b1, i, s, d};
        @(negedge clk_i);
        {wr_en_o, wr_data_o} = {1'b0, ~d};
        @(negedge clk_i);
    endtask
    // data is there at the following falling edge
    task automatic rd(input logic [2:0] i, input logic [1:0] s);
        {rd_idx_o, rd_size_o} = {i, s};
        @(negedge clk_i);
    endtask
endmodule // x86rf_pipe_model
`default_nettype wire

// file: sim/x86rf_regfile_tb.sv
// self-checking bench for the general and segment register file
// assumes the pipeline model drives the explicit write port and read port a; the bench drives read port b
`timescale 1ns/1ps
`default_nettype none
`include "x86rf_consts.vh"

module x86rf_regfile_tb;
    localparam logic [1:0] L8 = `X86RF_SZ_LOW8, H8 = `X86RF_SZ_HIGH8;
    localparam logic [1:0] W16 = `X86RF_SZ_W16, W32 = `X86RF_SZ_W32;
    logic        clk_i, rstn_i, ce, stp, dec, sen, den, rep, sa32;
    logic        ka32, swe, ov, prot, v86, wen, zf, issel;
    logic [2:0]  eb, kb, sidx, rk, os, rb, wi, ri, ssel;
    logic [1:0]  kop, ws, rs, rbs;
    logic [15:0] sd, sv, selr;
    logic [31:0] wd, rda, rdb, src, dst, cnt, sp, base;
    int          err_total = 0, checked = 0, cyc = 0;

    x86rf_pipe_model u_pipe (.clk_i(clk_i), .wr_en_o(wen), .wr_idx_o(wi),
        .wr_size_o(ws), .wr_data_o(wd), .rd_idx_o(ri), .rd_size_o(rs));
    x86rf_regfile u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(ce),
        .rd_a_idx_i(ri), .rd_a_size_i(rs), .rd_a_data_o(rda),
        .rd_b_idx_i(rb), .rd_b_size_i(rbs), .rd_b_data_o(rdb),
        .wr_en_i(wen), .wr_idx_i(wi), .wr_size_i(ws), .wr_data_i(wd),
        .str_step_i(stp), .str_dir_dec_i(dec), .str_src_en_i(sen),
        .str_dst_en_i(den), .str_rep_i(rep), .str_elem_bytes_i(eb),
        .str_addr32_i(sa32), .str_src_o(src), .str_dst_o(dst),
        .str_count_o(cnt), .str_count_zero_o(zf), .stk_op_i(kop),
        .stk_bytes_i(kb), .stk_addr32_i(ka32), .stack_ptr_o(sp),
        .seg_wr_en_i(swe), .seg_wr_idx_i(sidx), .seg_wr_data_i(sd),
        .ref_kind_i(rk), .ovr_valid_i(ov), .ovr_seg_i(os),
        .prot_mode_i(prot), .v86_mode_i(v86), .seg_sel_idx_o(ssel),
        .seg_value_o(sv), .seg_real_base_o(base), .seg_selector_o(selr),
        .seg_is_selector_o(issel));

    task automatic chk(input string nm, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic t_bytes;
        for (int k = 0; k < 4; k++) begin
            u_pipe.wr(3'(k), W32, 32'h1122_3344);
            u_pipe.wr(3'(k), H8, 32'hab);
            {rb, rbs} = {3'(k), H8};
            u_pipe.rd(3'(k), L8);
            chk("low byte", 32'h44, rda);
            chk("b high", 32'hab, rdb);
            u_pipe.wr(3'(k), L8, 32'hcd);
            u_pipe.rd(3'(k), W16);
            chk("word", 32'habcd, rda);
            u_pipe.wr(3'(k), W16, 32'hffff_5678);
            u_pipe.rd(3'(k), W32);
            chk("full", 32'h1122_5678, rda);
        end
        $display("bytes done");
    endtask
    task automatic t_ptr;
        for (int k = 4; k < 8; k++) begin
            u_pipe.wr(3'(k), W32, 32'h8765_0000 + k);
            {rb, rbs} = {3'(k), W32};
            u_pipe.rd(3'(k), W16);
            chk("ptr word", 32'(k), rda);
            chk("ptr full", 32'h8765_0000 + k, rdb);
        end
        $display("pointers done");
    endtask
    task automatic t_str;
        u_pipe.wr(3'h6, W32, 32'h100);
        u_pipe.wr(3'h7, W32, 32'h200);
        u_pipe.wr(3'h1, W32, 32'h2);
        {stp, sen, den, rep, sa32, eb} = {5'h1f, 3'h4};
        repeat (2) @(negedge clk_i);
        chk("src", 32'h108, src);
        chk("dst", 32'h208, dst);
        chk("zero", 32'h1, {31'h0, zf});
        {dec, eb} = {1'b1, 3'h1};
        @(negedge clk_i);
        {stp, dec} = 2'h0;
        chk("src back", 32'h107, src);
        chk("cnt held", 32'h0, cnt);
        u_pipe.wr(3'h6, W32, 32'h0003_0000);
        u_pipe.wr(3'h1, W32, 32'h0001_0000);
        {stp, dec, sa32, eb} = {1'b1, 1'b1, 1'b0, 3'h2};
        @(negedge clk_i);
        stp = 1'b0;
        chk("src wrap", 32'h0003_fffe, src);
        chk("dst 16", 32'h0000_0205, dst);
        chk("cnt 16 zero", 32'h0001_0000, cnt);
        chk("zero 16", 32'h1, {31'h0, zf});
        $display("string done");
    endtask
    task automatic stk(input logic [1:0] o, input logic [2:0] b,
                       input logic a, input logic [31:0] e);
        {kop, kb, ka32} = {o, b, a};
        @(negedge clk_i);
        chk("stack ptr", e, sp);
    endtask
    task automatic t_stk;
        u_pipe.wr(3'h4, W32, 32'h0001_0000);
        stk(`X86RF_STK_PUSH, 3'h2, 1'b0, 32'h0001_fffe);
        stk(`X86RF_STK_POP, 3'h4, 1'b1, 32'h0002_0002);
        stk(`X86RF_STK_PUSH, 3'h4, 1'b1, 32'h0001_fffe);
        // clock enable low: the push must not land
        ce = 1'b0;
        stk(`X86RF_STK_PUSH, 3'h4, 1'b1, 32'h0001_fffe);
        {ce, kop} = {1'b1, 2'h0};
        u_pipe.wr(3'h4, W16, 32'hdead_1234);
        chk("sp word", 32'h0001_1234, sp);
        u_pipe.rd(3'h4, W32);
        chk("sp full", 32'h0001_1234, rda);
        $display("stack done");
    endtask
    task automatic sel(input logic [2:0] k, input logic v,
                       input logic [2:0] s, input logic [2:0] e);
        {rk, ov, os} = {k, v, s};
        @(negedge clk_i);
        chk("seg pick", 32'(e), 32'(ssel));
        chk("seg value", 32'h1230 + e, 32'(sv));
    endtask
    task automatic t_seg;
        swe = 1'b1;
        for (int k = 0; k < 6; k++) begin
            {sidx, sd} = {3'(k), 16'h1230 + 16'(k)};
            @(negedge clk_i);
        end
        swe = 1'b0;
        sel(`X86RF_REF_FETCH, 1'b1, `X86RF_SEG_AUX1, `X86RF_SEG_CODE);
        sel(`X86RF_REF_STACK, 1'b1, `X86RF_SEG_EXTRA, `X86RF_SEG_STACK);
        sel(`X86RF_REF_STRDST, 1'b1, `X86RF_SEG_AUX2, `X86RF_SEG_EXTRA);
        sel(`X86RF_REF_STRSRC, 1'b1, `X86RF_SEG_AUX1, `X86RF_SEG_AUX1);
        for (int k = 0; k < 6; k++)
            sel(`X86RF_REF_DATA, 1'b1, 3'(k), 3'(k));
        sel(`X86RF_REF_BPDATA, 1'b0, 3'h0, `X86RF_SEG_STACK);
        sel(`X86RF_REF_BPDATA, 1'b1, `X86RF_SEG_AUX2, `X86RF_SEG_AUX2);
        sel(`X86RF_REF_DATA, 1'b1, 3'h6, `X86RF_SEG_DATA);
        sel(`X86RF_REF_DATA, 1'b0, 3'h0, `X86RF_SEG_DATA);
        chk("real base", 32'h0001_2330, base);
        chk("real sel", 32'h0, 32'(selr));
        chk("real kind", 32'h0, 32'(issel));
        {prot, v86} = 2'h2;
        @(negedge clk_i);
        chk("selector", 32'h1233, 32'(selr));
        chk("prot base", 32'h0, base);
        chk("prot kind", 32'h1, 32'(issel));
        v86 = 1'b1;
        @(negedge clk_i);
        chk("v86 base", 32'h0001_2330, base);
        chk("v86 kind", 32'h0, 32'(issel));
        $display("segments done");
    endtask

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            final_report();
        end
    end
    initial begin
        {stp, dec, sen, den, rep, sa32, ka32, swe, ov, prot, v86} = '0;
        {eb, kb, sidx, rk, os, rb, kop, sd, rbs} = '0;
        {rstn_i, ce} = 2'h1;
        repeat (12) @(negedge clk_i);
        rstn_i = 1'b1;
        repeat (3) @(negedge clk_i);
        t_bytes();
        t_ptr();
        t_str();
        t_stk();
        t_seg();
        final_report();
    end
endmodule // x86rf_regfile_tb
`default_nettype wire
